// ---- core/std_top.sv ----
/*
  Supervisor trap delegation unit of one hart: delegation masks, shared
  status storage with machine and supervisor views, supervisor enables,
  pending bits, vector, cause and exception PC, plus the routing of traps.
  Assumes the pipeline presents at most one trap per cycle and one
  register access per cycle, both synchronous to clk_sys.

  // Summary of operation
  // - Set delegation mask bit sends that interrupt to supervisor mode.
  // - Interrupt mask holds only bits 1, 5 and 9; rest read zero.
  // - Exception mask holds codes 0-9, 12, 13, 15; rest read zero.
  // - Delegated trap loads cause and PC, vectors to supervisor base.
  // - Local interrupts always go to machine mode.
  // - Machine write to pending register sets supervisor pending bits.
  // - Supervisor status is an alias of machine status, same storage.
  // - Machine-only status fields read zero through supervisor view.
  // - Supervisor interrupt needs global enable and its own enable.
  // - Status bit 5 keeps the enable value from before the trap.
  // - Status bit 8 keeps the privilege from before the trap.
  // - Enable register bit 1 enables software interrupt.
  // - Enable register bit 5 enables timer interrupt.
  // - Enable register bit 9 enables external interrupt; rest ignored.
  // - Cause top bit is one for interrupts, zero for exceptions.
*/
`timescale 1ns/1ns
module std_top (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  input  wire logic                          csr_valid,
  input  wire logic                          csr_write,
  input  wire logic [std_pkg::ADDR_W-1:0]    csr_addr,
  input  wire logic [std_pkg::XLEN-1:0]      csr_wdata,
  input  wire std_pkg::std_priv_t            csr_priv,
  output logic      [std_pkg::XLEN-1:0]      csr_rdata,
  output logic                               csr_rvalid,
  output logic                               csr_err,
  input  wire logic                          trap_valid,
  input  wire logic                          trap_is_irq,
  input  wire logic [std_pkg::CODE_W-1:0]    trap_code,
  input  wire logic [std_pkg::XLEN-1:0]      trap_pc,
  input  wire std_pkg::std_priv_t            trap_priv,
  output logic                               trap_to_super,
  output logic                               trap_to_machine,
  output logic      [std_pkg::XLEN-1:0]      super_vector,
  input  wire logic [std_pkg::XLEN-1:0]      sup_hw_pend,
  output logic                               sup_irq_req,
  output logic      [std_pkg::CODE_W-1:0]    sup_irq_code
);
  import std_pkg::*;

  std_state_t       st_reg;
  std_state_t       st_next;
  logic             rst_q;
  logic [XLEN-1:0]  eff_pend;
  logic [XLEN-1:0]  avail;
  logic [XLEN-1:0]  rd_val;
  logic             hit;
  logic             m_only;
  logic             m_wr_only;
  logic             acc_ok;
  logic             wr_en;

  std_route_if rif ();

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  assign rif.ideleg = st_reg.ideleg;
  assign rif.edeleg = st_reg.edeleg;
  assign rif.is_irq = trap_is_irq;
  assign rif.code   = trap_code;

  std_trap_route u_route (
    .rif (rif)
  );

  assign rst_q           = st_reg.rst_sync[1];
  assign trap_to_super   = rst_q && trap_valid && rif.delegate;
  assign trap_to_machine = rst_q && trap_valid && !rif.delegate;
  assign super_vector    = st_reg.stvec;

  // ----------------------------------------------------------------
  // Supervisor interrupt request
  // ----------------------------------------------------------------
  // Hardware pending levels are not sticky; software-set bits are
  assign eff_pend = (st_reg.pend | sup_hw_pend) & PEND_MASK;
  assign avail    = eff_pend & st_reg.ienable & st_reg.ideleg;

  always_comb begin
    sup_irq_req  = rst_q && st_reg.status[ST_SIE] && (|avail);
    sup_irq_code = IRQ_EXT;
    if (avail[IRQ_EXT]) begin
      sup_irq_code = IRQ_EXT;
    end else if (avail[IRQ_SOFT]) begin
      sup_irq_code = IRQ_SOFT;
    end else if (avail[IRQ_TIMER]) begin
      sup_irq_code = IRQ_TIMER;
    end
  end

  // ----------------------------------------------------------------
  // Register access and trap entry
  // ----------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
    rd_val         = RESET_WORD;
    hit            = 1'b0;
    m_only         = (csr_addr == ADDR_IDELEG) || (csr_addr == ADDR_EDELEG) || (csr_addr == ADDR_MSTATUS);
    m_wr_only      = m_only || (csr_addr == ADDR_SPEND);
    acc_ok         = (csr_priv == STD_PRIV_M) ||
                     ((csr_priv == STD_PRIV_S) && !(csr_write ? m_wr_only : m_only));
    wr_en          = csr_valid && csr_write && acc_ok;
    if (ce && rst_q) begin
      st_next.rvalid = 1'b0;
      st_next.err    = 1'b0;
      if (csr_valid) begin
        unique case (csr_addr)
          ADDR_IDELEG: begin
            hit    = 1'b1;
            rd_val = st_reg.ideleg;
            if (wr_en) begin
              st_next.ideleg = csr_wdata & IDELEG_MASK;
            end
          end
          ADDR_EDELEG: begin
            hit    = 1'b1;
            rd_val = st_reg.edeleg;
            if (wr_en) begin
              st_next.edeleg = csr_wdata & EDELEG_MASK;
            end
          end
          ADDR_MSTATUS: begin
            hit    = 1'b1;
            rd_val = st_reg.status;
            if (wr_en) begin
              st_next.status = csr_wdata & MSTATUS_MASK;
            end
          end
          ADDR_SSTATUS: begin
            hit    = 1'b1;
            rd_val = st_reg.status & SSTATUS_MASK;
            if (wr_en) begin
              // Only supervisor fields change; machine fields keep their value
              st_next.status = (st_reg.status & ~SSTATUS_MASK) | (csr_wdata & SSTATUS_MASK);
            end
          end
          ADDR_SIE: begin
            hit    = 1'b1;
            rd_val = st_reg.ienable;
            if (wr_en) begin
              st_next.ienable = csr_wdata & SIE_MASK;
            end
          end
          ADDR_SPEND: begin
            hit    = 1'b1;
            rd_val = eff_pend;
            if (wr_en) begin
              st_next.pend = csr_wdata & PEND_MASK;
            end
          end
          ADDR_STVEC: begin
            hit    = 1'b1;
            rd_val = st_reg.stvec;
            if (wr_en) begin
              st_next.stvec = csr_wdata & STVEC_MASK;
            end
          end
          ADDR_SCAUSE: begin
            hit    = 1'b1;
            rd_val = st_reg.scause;
            if (wr_en) begin
              st_next.scause = csr_wdata;
            end
          end
          ADDR_SUPERVISOR_EXCEPTION_PC: begin
            hit    = 1'b1;
            rd_val = st_reg.supervisor_exception_pc;
            if (wr_en) begin
              st_next.supervisor_exception_pc = csr_wdata;
            end
          end
          default: begin
            hit = 1'b0;
          end
        endcase
        st_next.rvalid = 1'b1;
        st_next.err    = !(hit && acc_ok);
        st_next.rdata  = (hit && acc_ok) ? rd_val : RESET_WORD;
      end
      // Trap entry comes last so it wins over a same-cycle register write
      if (trap_to_super) begin
        st_next.scause = {trap_is_irq, {(XLEN-1-CODE_W){1'b0}}, trap_code};
        st_next.supervisor_exception_pc   = trap_pc;
        st_next.status[ST_PREVIOUS_SUPERVISOR_ENABLE] = st_reg.status[ST_SIE];
        st_next.status[ST_SIE]  = 1'b0;
        st_next.status[ST_SPP]  = (trap_priv != STD_PRIV_U);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset sync runs regardless of ce so release never stalls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign csr_rdata  = st_reg.rdata;
  assign csr_rvalid = st_reg.rvalid;
  assign csr_err    = st_reg.err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_q);

  a_ideleg_legal: assert property ((st_reg.ideleg & ~IDELEG_MASK) == RESET_WORD)
    else $error("interrupt delegation mask holds a reserved bit");

  a_edeleg_legal: assert property ((st_reg.edeleg & ~EDELEG_MASK) == RESET_WORD)
    else $error("exception delegation mask holds a reserved bit");

  a_local_stays_m: assert property (trap_valid && trap_is_irq && (trap_code >= IRQ_LOCAL_MIN)
                                    |-> trap_to_machine && !trap_to_super)
    else $error("local interrupt was delegated");

  a_irq_routed: assert property (trap_valid && trap_is_irq && (trap_code < IRQ_LOCAL_MIN)
                                 |-> (trap_to_super == st_reg.ideleg[trap_code]))
    else $error("interrupt routing disagrees with delegation mask");

  a_cause_copy: assert property (ce && trap_to_super |=>
                                 st_reg.scause[CAUSE_IRQ_BIT] == $past(trap_is_irq) &&
                                 st_reg.scause[CODE_W-1:0] == $past(trap_code) &&
                                 st_reg.supervisor_exception_pc == $past(trap_pc))
    else $error("cause or exception PC not copied on delegated trap");

  a_enable_stack: assert property (ce && trap_to_super |=>
                                   !st_reg.status[ST_SIE] &&
                                   st_reg.status[ST_PREVIOUS_SUPERVISOR_ENABLE] == $past(st_reg.status[ST_SIE]))
    else $error("supervisor enable not stacked on trap entry");

  a_prev_priv: assert property (ce && trap_to_super |=>
                                st_reg.status[ST_SPP] == ($past(trap_priv) != STD_PRIV_U))
    else $error("previous privilege not recorded");

  a_sview_mask: assert property (ce && csr_valid && !csr_write && csr_addr == ADDR_SSTATUS &&
                                 csr_priv == STD_PRIV_S |=> csr_rvalid && !csr_err &&
                                 csr_rdata == ($past(st_reg.status) & SSTATUS_MASK))
    else $error("supervisor status view shows wrong bits");

  a_sie_gate: assert property (sup_irq_req |-> st_reg.status[ST_SIE] &&
                               st_reg.ienable[sup_irq_code] && eff_pend[sup_irq_code])
    else $error("supervisor interrupt requested while disabled");

  a_pend_write: assert property (ce && csr_valid && csr_write && csr_addr == ADDR_SPEND &&
                                 csr_priv == STD_PRIV_M |=> st_reg.pend == ($past(csr_wdata) & PEND_MASK))
    else $error("machine write did not set pending bits");

  a_enable_bits: assert property ((st_reg.ienable & ~SIE_MASK) == RESET_WORD)
    else $error("enable register holds a reserved bit");

  // A frozen cycle must leave cause, exception PC and status untouched
  a_ce_hold: assert property (!ce |=> st_reg.scause == $past(st_reg.scause) &&
                              st_reg.supervisor_exception_pc == $past(st_reg.supervisor_exception_pc) && st_reg.status == $past(st_reg.status))
    else $error("state changed while clock enable was low");

  c_irq_delegated: cover property (trap_to_super && trap_is_irq);
  c_exc_delegated: cover property (trap_to_super && !trap_is_irq);
  c_sup_irq:       cover property (sup_irq_req);
  c_bad_access:    cover property (csr_err);

endmodule

// ---- core/std_pkg.sv ----
/*
  Shared constants and types for the supervisor trap delegation block:
  register addresses, legal-bit masks, status field positions, privilege
  codes, interrupt codes and the registered state of the control unit.
  Assumes a 64-bit hart with a 12-bit register address space.
*/
package std_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int XLEN   = 64;
  localparam int CODE_W = 6;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_IDELEG  = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_EDELEG  = 12'h001;
  localparam logic [ADDR_W-1:0] ADDR_MSTATUS = 12'h002;
  localparam logic [ADDR_W-1:0] ADDR_SSTATUS = 12'h003;
  localparam logic [ADDR_W-1:0] ADDR_SIE     = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_SPEND   = 12'h005;
  localparam logic [ADDR_W-1:0] ADDR_STVEC   = 12'h006;
  localparam logic [ADDR_W-1:0] ADDR_SCAUSE  = 12'h007;
  localparam logic [ADDR_W-1:0] ADDR_SUPERVISOR_EXCEPTION_PC    = 12'h008;

  // ----------------------------------------------------------------
  // Legal-bit masks
  // ----------------------------------------------------------------
  localparam logic [XLEN-1:0] IDELEG_MASK  = 64'h0000_0000_0000_0222;
  localparam logic [XLEN-1:0] EDELEG_MASK  = 64'h0000_0000_0000_b3ff;
  localparam logic [XLEN-1:0] SSTATUS_MASK = 64'h0000_0000_0000_0122;
  localparam logic [XLEN-1:0] MSTATUS_MASK = 64'h0000_0000_0000_012a;
  localparam logic [XLEN-1:0] SIE_MASK     = 64'h0000_0000_0000_0222;
  localparam logic [XLEN-1:0] PEND_MASK    = 64'h0000_0000_0000_0222;
  localparam logic [XLEN-1:0] STVEC_MASK   = 64'hffff_ffff_ffff_fffc;
  localparam logic [XLEN-1:0] RESET_WORD   = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Status fields and interrupt codes
  // ----------------------------------------------------------------
  localparam int ST_SIE  = 1;
  localparam int ST_MIE  = 3;
  localparam int ST_PREVIOUS_SUPERVISOR_ENABLE = 5;
  localparam int ST_SPP  = 8;
  localparam int CAUSE_IRQ_BIT = 63;

  localparam logic [CODE_W-1:0] IRQ_SOFT      = 6'h01;
  localparam logic [CODE_W-1:0] IRQ_TIMER     = 6'h05;
  localparam logic [CODE_W-1:0] IRQ_EXT       = 6'h09;
  localparam logic [CODE_W-1:0] IRQ_LOCAL_MIN = 6'h10;

  typedef enum logic [1:0] {
    STD_PRIV_U = 2'b00,
    STD_PRIV_S = 2'b01,
    STD_PRIV_M = 2'b11
  } std_priv_t;

  typedef struct packed {
    logic [1:0]      rst_sync;
    logic [XLEN-1:0] ideleg;
    logic [XLEN-1:0] edeleg;
    logic [XLEN-1:0] status;
    logic [XLEN-1:0] ienable;
    logic [XLEN-1:0] pend;
    logic [XLEN-1:0] stvec;
    logic [XLEN-1:0] scause;
    logic [XLEN-1:0] supervisor_exception_pc;
    logic [XLEN-1:0] rdata;
    logic            rvalid;
    logic            err;
  } std_state_t;

endpackage

// ---- core/std_route_if.sv ----
/*
  Carrier between the control unit and its delegation router: the two
  delegation masks and the pending trap go out, the routing decision
  comes back. Purely combinational; no clock travels here.
*/
`timescale 1ns/1ns
interface std_route_if;
  import std_pkg::*;
  logic [XLEN-1:0]   ideleg;
  logic [XLEN-1:0]   edeleg;
  logic              is_irq;
  logic [CODE_W-1:0] code;
  logic              delegate;

  modport ctl (output ideleg, output edeleg, output is_irq, output code, input delegate);
  modport rt  (input ideleg, input edeleg, input is_irq, input code, output delegate);
endinterface

// ---- core/std_trap_route.sv ----
/*
  Delegation router: decides whether a trap goes to supervisor mode.
  Assumes the masks it receives already hold only legal bits.
*/
`timescale 1ns/1ns
module std_trap_route (
  std_route_if.rt rif
);
  import std_pkg::*;

  // ----------------------------------------------------------------
  // Routing decision
  // ----------------------------------------------------------------
  always_comb begin
    if (rif.is_irq) begin
      // Local interrupts stay in machine mode whatever the mask says
      rif.delegate = (rif.code < IRQ_LOCAL_MIN) && rif.ideleg[rif.code];
    end else begin
      rif.delegate = rif.edeleg[rif.code];
    end
  end
endmodule

// ---- tb/std_top_tb_top.sv ----
/*
  Self-checking bench for the supervisor trap delegation unit: register
  masks, status aliasing, refusals, interrupt request, trap routing, reset.
  Assumes std_top keeps its own assertions; inputs change at falling edges.
*/
`timescale 1ns/1ns
module std_top_tb_top;
  import std_pkg::*;

  typedef struct {
    logic [ADDR_W-1:0] addr;
    logic [XLEN-1:0]   wd;
    logic [XLEN-1:0]   exp;
  } std_row_t;

  logic              clk_sys     = 1'b0;
  logic              rst_b       = 1'b0;
  logic              ce          = 1'b1;
  logic              csr_valid   = 1'b0;
  logic              csr_write   = 1'b0;
  logic [ADDR_W-1:0] csr_addr    = 12'h000;
  logic [XLEN-1:0]   csr_wdata   = 64'h0000_0000_0000_0000;
  std_priv_t         csr_priv    = STD_PRIV_M;
  logic [XLEN-1:0]   csr_rdata;
  logic              csr_rvalid;
  logic              csr_err;
  logic              trap_valid  = 1'b0;
  logic              trap_is_irq = 1'b0;
  logic [CODE_W-1:0] trap_code   = 6'h00;
  logic [XLEN-1:0]   trap_pc     = 64'h0000_0000_0000_0000;
  std_priv_t         trap_priv   = STD_PRIV_U;
  logic              trap_to_super;
  logic              trap_to_machine;
  logic [XLEN-1:0]   super_vector;
  logic [XLEN-1:0]   sup_hw_pend = 64'h0000_0000_0000_0000;
  logic              sup_irq_req;
  logic [CODE_W-1:0] sup_irq_code;
  logic [XLEN-1:0]   rd_word;
  logic              rd_err;
  int                err_count   = 0;
  int                comparisons = 0;
  int                cycles      = 0;
  std_row_t          rows [8];

  always #5 clk_sys = ~clk_sys;

  std_top u_std_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .csr_valid(csr_valid), .csr_write(csr_write),
    .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_priv(csr_priv), .csr_rdata(csr_rdata),
    .csr_rvalid(csr_rvalid), .csr_err(csr_err), .trap_valid(trap_valid), .trap_is_irq(trap_is_irq),
    .trap_code(trap_code), .trap_pc(trap_pc), .trap_priv(trap_priv), .trap_to_super(trap_to_super),
    .trap_to_machine(trap_to_machine), .super_vector(super_vector), .sup_hw_pend(sup_hw_pend),
    .sup_irq_req(sup_irq_req), .sup_irq_code(sup_irq_code)
  );

  // ----------------------------------------------------------------
  // Compare, bus and trap tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [XLEN-1:0] got, input logic [XLEN-1:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One request per call; the answer pulse is caught in the cycle after the taking edge
  task automatic csr(input logic wr, input logic [ADDR_W-1:0] a, input logic [XLEN-1:0] wd, input std_priv_t pv);
    @(negedge clk_sys);
    csr_valid = 1'b1;
    csr_write = wr;
    csr_addr  = a;
    csr_wdata = wd;
    csr_priv  = pv;
    @(negedge clk_sys);
    chk({63'h0, csr_rvalid}, 64'h0000_0000_0000_0001, "answer pulse");
    rd_word   = csr_rdata;
    rd_err    = csr_err;
    csr_valid = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input std_priv_t pv, input logic [XLEN-1:0] exp, input logic e);
    csr(1'b0, a, 64'h0000_0000_0000_0000, pv);
    chk(rd_word, exp, "read data");
    chk({63'h0, rd_err}, {63'h0, e}, "refusal flag");
  endtask

  task automatic trap(input logic irq, input logic [CODE_W-1:0] code, input std_priv_t pv, input logic sup);
    @(negedge clk_sys);
    trap_valid  = 1'b1;
    trap_is_irq = irq;
    trap_code   = code;
    trap_priv   = pv;
    trap_pc     = 64'h1234_5678_9abc_def0;
    #1;
    chk({62'h0, trap_to_super, trap_to_machine}, {62'h0, sup, !sup}, "trap route");
    @(negedge clk_sys);
    trap_valid  = 1'b0;
  endtask

  task automatic irq_chk(input logic req, input logic [CODE_W-1:0] code);
    #1;
    chk({57'h0, sup_irq_req, sup_irq_code}, {57'h0, req, req ? code : sup_irq_code}, "irq request");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1500) begin
      err_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{ADDR_IDELEG,  64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0222};
    rows[1] = '{ADDR_EDELEG,  64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_b3ff};
    rows[2] = '{ADDR_SSTATUS, 64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0122};
    rows[3] = '{ADDR_SIE,     64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0222};
    rows[4] = '{ADDR_SPEND,   64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0222};
    rows[5] = '{ADDR_STVEC,   64'hffff_ffff_ffff_ffff, 64'hffff_ffff_ffff_fffc};
    rows[6] = '{ADDR_SCAUSE,  64'ha5a5_0000_ffff_5a5a, 64'ha5a5_0000_ffff_5a5a};
    rows[7] = '{ADDR_SUPERVISOR_EXCEPTION_PC,    64'h0123_4567_89ab_cdef, 64'h0123_4567_89ab_cdef};
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    foreach (rows[i]) begin
      csr(1'b1, rows[i].addr, rows[i].wd, STD_PRIV_M);
      rd(rows[i].addr, STD_PRIV_M, rows[i].exp, 1'b0);
    end
    chk(super_vector, 64'hffff_ffff_ffff_fffc, "vector");
    // Enables, pending and delegation are all set: external wins, then software, then timer
    irq_chk(1'b1, IRQ_EXT);
    csr(1'b1, ADDR_SIE, 64'h0000_0000_0000_0022, STD_PRIV_S);
    irq_chk(1'b1, IRQ_SOFT);
    csr(1'b1, ADDR_SIE, 64'h0000_0000_0000_0020, STD_PRIV_S);
    irq_chk(1'b1, IRQ_TIMER);
    csr(1'b1, ADDR_SSTATUS, 64'h0000_0000_0000_0020, STD_PRIV_S);
    irq_chk(1'b0, IRQ_TIMER);
    csr(1'b1, ADDR_SSTATUS, 64'h0000_0000_0000_0002, STD_PRIV_S);
    csr(1'b1, ADDR_SPEND, 64'h0000_0000_0000_0000, STD_PRIV_M);
    irq_chk(1'b0, IRQ_TIMER);
    // Refusals leave state alone
    rd(ADDR_IDELEG, STD_PRIV_S, 64'h0000_0000_0000_0000, 1'b1);
    rd(ADDR_SIE, STD_PRIV_U, 64'h0000_0000_0000_0000, 1'b1);
    csr(1'b1, ADDR_SPEND, 64'h0000_0000_0000_0020, STD_PRIV_S);
    chk({63'h0, rd_err}, 64'h0000_0000_0000_0001, "pend write refused");
    rd(ADDR_SPEND, STD_PRIV_S, 64'h0000_0000_0000_0000, 1'b0);
    rd(12'h0ff, STD_PRIV_M, 64'h0000_0000_0000_0000, 1'b1);
    // Delegated timer interrupt from user mode with enable set
    trap(1'b1, IRQ_TIMER, STD_PRIV_U, 1'b1);
    rd(ADDR_SCAUSE, STD_PRIV_M, 64'h8000_0000_0000_0005, 1'b0);
    rd(ADDR_SUPERVISOR_EXCEPTION_PC, STD_PRIV_M, 64'h1234_5678_9abc_def0, 1'b0);
    rd(ADDR_SSTATUS, STD_PRIV_S, 64'h0000_0000_0000_0020, 1'b0);
    // Delegated page fault from supervisor mode, enable already clear
    trap(1'b0, 6'h0d, STD_PRIV_S, 1'b1);
    rd(ADDR_SCAUSE, STD_PRIV_M, 64'h0000_0000_0000_000d, 1'b0);
    rd(ADDR_SSTATUS, STD_PRIV_S, 64'h0000_0000_0000_0100, 1'b0);
    trap(1'b0, 6'h0e, STD_PRIV_U, 1'b0);
    trap(1'b0, 6'h0b, STD_PRIV_U, 1'b0);
    trap(1'b1, IRQ_LOCAL_MIN, STD_PRIV_U, 1'b0);
    trap(1'b1, 6'h03, STD_PRIV_U, 1'b0);
    rd(ADDR_SCAUSE, STD_PRIV_M, 64'h0000_0000_0000_000d, 1'b0);
    csr(1'b1, ADDR_IDELEG, 64'h0000_0000_0000_0000, STD_PRIV_M);
    trap(1'b1, IRQ_SOFT, STD_PRIV_U, 1'b0);
    // Hardware pending level with delegation off, then on
    csr(1'b1, ADDR_SIE, 64'h0000_0000_0000_0200, STD_PRIV_S);
    csr(1'b1, ADDR_SSTATUS, 64'h0000_0000_0000_0002, STD_PRIV_S);
    sup_hw_pend = 64'h0000_0000_0000_0200;
    irq_chk(1'b0, IRQ_EXT);
    csr(1'b1, ADDR_IDELEG, 64'h0000_0000_0000_0200, STD_PRIV_M);
    irq_chk(1'b1, IRQ_EXT);
    sup_hw_pend = 64'h0000_0000_0000_0000;
    // Both views share one storage; machine-only bit hidden from supervisor
    csr(1'b1, ADDR_MSTATUS, 64'hffff_ffff_ffff_ffff, STD_PRIV_M);
    rd(ADDR_MSTATUS, STD_PRIV_M, 64'h0000_0000_0000_012a, 1'b0);
    rd(ADDR_SSTATUS, STD_PRIV_S, 64'h0000_0000_0000_0122, 1'b0);
    csr(1'b1, ADDR_SSTATUS, 64'h0000_0000_0000_0000, STD_PRIV_S);
    rd(ADDR_MSTATUS, STD_PRIV_M, 64'h0000_0000_0000_0008, 1'b0);
    // Clock enable low freezes state and holds back the answer
    @(negedge clk_sys);
    ce        = 1'b0;
    csr_valid = 1'b1;
    csr_write = 1'b1;
    csr_addr  = ADDR_SCAUSE;
    csr_wdata = 64'hffff_ffff_ffff_ffff;
    csr_priv  = STD_PRIV_M;
    repeat (2) @(negedge clk_sys);
    chk({63'h0, csr_rvalid}, 64'h0000_0000_0000_0000, "no answer while frozen");
    csr_valid = 1'b0;
    ce        = 1'b1;
    rd(ADDR_SCAUSE, STD_PRIV_M, 64'h0000_0000_0000_000d, 1'b0);
    // Second reset in mid-run clears everything
    @(negedge clk_sys);
    rst_b = 1'b0;
    #1;
    chk({61'h0, csr_rvalid, csr_err, sup_irq_req}, 64'h0000_0000_0000_0000, "outputs in reset");
    chk(super_vector, 64'h0000_0000_0000_0000, "vector in reset");
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    foreach (rows[i]) begin
      rd(rows[i].addr, STD_PRIV_M, 64'h0000_0000_0000_0000, 1'b0);
    end
    print_verdict();
  end
endmodule
